// File: emg_pkg.sv
// Constants for the event mask and global event flag block
// Contract
// - Mask bit 1 gates power-good events from all ports onto the alert pin.
// - Mask bit 1 clear blocks power-good events from the pin; event still recorded.
// - Mask bit 0 gates power-enabled events from all ports onto the alert pin.
// - Offset 0x03 reads exactly the same contents as offset 0x02.
// - Reading 0x03 clears the one flag register behind both offsets; reading 0x02 changes nothing.
// - Flags set again within milliseconds while the fault persists; gone faults stay clear.
// - Mask one passes, zero blocks; reset leaves only the status bit set.
package emg_pkg;
  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MASK      = 8'h01;
  localparam logic [7:0] ADDR_FLAGS     = 8'h02;
  localparam logic [7:0] ADDR_FLAGS_COR = 8'h03;
  localparam logic [7:0] MASK_RESET     = 8'h80;
  localparam logic [7:0] FLAGS_RESET    = 8'h20;
  // Bits 2:0 of the flag register are reserved and read as zero
  localparam logic [7:0] FLAGS_USED     = 8'hF8;
  // ----------------------------------------------------------------
  // Mask field positions
  // ----------------------------------------------------------------
  localparam int MASK_PWRENA = 0;
  localparam int MASK_PWRGD  = 1;
  localparam int MASK_DET    = 2;
  localparam int MASK_CLASS  = 3;
  localparam int MASK_DIS    = 4;
  localparam int MASK_STATUS = 7;
  localparam int NUM_TYPES   = 5;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ         = 25_000_000;
  localparam int REFRESH_MS     = 2;
  localparam int REFRESH_CYCLES = CLK_HZ / 1000 * REFRESH_MS;
  localparam int CNT_W          = 17;
endpackage

// File: emg_tick.sv
// Free running divider giving one refresh pulse per period
`timescale 1ns/1ns
module emg_tick
  import emg_pkg::*;
#(
  parameter int PERIOD = REFRESH_CYCLES
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  output logic      tick_o
);
  logic [CNT_W-1:0] count;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      count <= '0;
    end else if (ce_i) begin
      if (count == CNT_W'(PERIOD - 1)) begin
        count <= '0;
      end else begin
        count <= count + CNT_W'(1);
      end
    end
  end

  assign tick_o = ce_i && (count == CNT_W'(PERIOD - 1));
endmodule

// File: emg_top.sv
// Event mask, alert pin latch and global event flag registers
`timescale 1ns/1ns
module emg_top
  import emg_pkg::*;
#(
  parameter int REFRESH = REFRESH_CYCLES
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic [7:0] ev_pwrena_i,
  input  wire logic [7:0] ev_pwrgd_i,
  input  wire logic [7:0] ev_det_i,
  input  wire logic [7:0] ev_class_i,
  input  wire logic [7:0] ev_dis_i,
  input  wire logic [7:0] fault_i,
  input  wire logic       alert_release_i,
  output logic            alert_o,
  output logic      [4:0] event_record_o
);
  logic [7:0] event_pin_mask;
  logic [7:0] device_event_flags;
  logic [7:0] fault_q;
  logic [4:0] ev_any;
  logic [4:0] ev_pass;
  logic       pin_src;
  logic       tick;
  logic       cor_read;
  logic [7:0] flag_set;
  logic [7:0] next_flags;

  // ----------------------------------------------------------------
  // Refresh timer
  // ----------------------------------------------------------------
  emg_tick #(
    .PERIOD (REFRESH)
  ) u_tick (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .tick_o    (tick)
  );

  // ----------------------------------------------------------------
  // Mask register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      event_pin_mask <= MASK_RESET;
    end else if (ce_i && reg_wr_i && reg_addr_i == ADDR_MASK) begin
      event_pin_mask <= reg_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Event gating onto the alert pin
  // ----------------------------------------------------------------
  assign ev_any[MASK_PWRENA] = |ev_pwrena_i;
  assign ev_any[MASK_PWRGD]  = |ev_pwrgd_i;
  assign ev_any[MASK_DET]    = |ev_det_i;
  assign ev_any[MASK_CLASS]  = |ev_class_i;
  assign ev_any[MASK_DIS]    = |ev_dis_i;
  // One mask bit per type covers all eight ports
  assign ev_pass = ev_any & event_pin_mask[NUM_TYPES-1:0];
  assign pin_src = (|ev_pass) || (event_pin_mask[MASK_STATUS] && (|device_event_flags));

  // Masked types are still recorded, so software can see what it blocked
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      event_record_o <= '0;
    end else if (ce_i) begin
      event_record_o <= (alert_release_i ? 5'h0_0 : event_record_o) | ev_any;
    end
  end

  // New events win over a release arriving in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      alert_o <= 1'b0;
    end else if (ce_i) begin
      alert_o <= (alert_o && !alert_release_i) || pin_src;
    end
  end

  // ----------------------------------------------------------------
  // Global event flags
  // ----------------------------------------------------------------
  assign cor_read = ce_i && reg_rd_i && reg_addr_i == ADDR_FLAGS_COR;
  // A new fault sets at once; a standing one is reasserted on each tick
  assign flag_set = fault_i & FLAGS_USED & ({8{tick}} | ~fault_q);
  assign next_flags = ((cor_read ? 8'h00 : device_event_flags) | flag_set) & FLAGS_USED;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      device_event_flags <= FLAGS_RESET;
      fault_q            <= 8'h00;
    end else if (ce_i) begin
      device_event_flags <= next_flags;
      fault_q            <= fault_i;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (ce_i && reg_rd_i) begin
      case (reg_addr_i)
        ADDR_MASK:      reg_rdata_o <= event_pin_mask;
        ADDR_FLAGS:     reg_rdata_o <= device_event_flags;
        ADDR_FLAGS_COR: reg_rdata_o <= device_event_flags;
        default:        reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  chk_pwrgd_pass: assert property (
    ce_i && (|ev_pwrgd_i) && event_pin_mask[MASK_PWRGD] |=> alert_o)
    else $error("power-good event did not raise alert");

  chk_alert_cause: assert property (
    $rose(alert_o) |-> $past(|(ev_any & event_pin_mask[4:0]))
      || $past(event_pin_mask[MASK_STATUS] && (|device_event_flags)))
    else $error("alert rose without a passed source");

  chk_pwrgd_record: assert property (
    ce_i && (|ev_pwrgd_i) |=> event_record_o[MASK_PWRGD])
    else $error("power-good event not recorded");

  chk_pwrena_pass: assert property (
    ce_i && (|ev_pwrena_i) && event_pin_mask[MASK_PWRENA] |=> alert_o)
    else $error("power-enabled event did not raise alert");

  chk_dis_pass: assert property (
    ce_i && (|ev_dis_i) && event_pin_mask[MASK_DIS] |=> alert_o)
    else $error("disconnect event did not raise alert");

  chk_mirror_read: assert property (
    ce_i && reg_rd_i && (reg_addr_i == ADDR_FLAGS || reg_addr_i == ADDR_FLAGS_COR)
      |=> reg_rdata_o == $past(device_event_flags))
    else $error("flag read does not match flag contents");

  chk_cor_clear: assert property (
    cor_read && flag_set == 8'h00 |=> device_event_flags == 8'h00)
    else $error("clear-on-read left flags set");

  chk_plain_read: assert property (
    ce_i && reg_rd_i && reg_addr_i == ADDR_FLAGS && flag_set == 8'h00
      |=> $stable(device_event_flags))
    else $error("plain flag read changed flags");

  chk_refresh_set: assert property (
    tick && (fault_i[7] == 1'b1) |=> device_event_flags[7])
    else $error("persisting fault not reasserted");

  chk_mask_write: assert property (
    ce_i && reg_wr_i && reg_addr_i == ADDR_MASK |=> event_pin_mask == $past(reg_wdata_i))
    else $error("mask write not stored");

  chk_mask_reset: assert property (disable iff (1'b0)
    rst_i |=> event_pin_mask == MASK_RESET)
    else $error("mask reset value wrong");

  chk_det_pass: assert property (
    ce_i && (|ev_det_i) && event_pin_mask[MASK_DET] |=> alert_o)
    else $error("detection event did not raise alert");

  chk_class_pass: assert property (
    ce_i && (|ev_class_i) && event_pin_mask[MASK_CLASS] |=> alert_o)
    else $error("classification event did not raise alert");

  chk_masked_quiet: assert property (
    ce_i && !alert_o && (ev_any & event_pin_mask[4:0]) == 5'h00
      && !(event_pin_mask[MASK_STATUS] && (|device_event_flags)) |=> !alert_o)
    else $error("masked event raised alert");

  chk_pwrgd_block: assert property (
    ce_i && !alert_o && ev_any == 5'h02 && !event_pin_mask[MASK_PWRGD]
      && !(event_pin_mask[MASK_STATUS] && (|device_event_flags)) |=> !alert_o)
    else $error("masked power-good event raised alert");

  chk_pwrena_block: assert property (
    ce_i && !alert_o && ev_any == 5'h01 && !event_pin_mask[MASK_PWRENA]
      && !(event_pin_mask[MASK_STATUS] && (|device_event_flags)) |=> !alert_o)
    else $error("masked power-enabled event raised alert");

  chk_record_release: assert property (
    ce_i && alert_release_i && ev_any == 5'h00 |=> event_record_o == 5'h00)
    else $error("event record not cleared by release");

  chk_status_pass: assert property (
    ce_i && event_pin_mask[MASK_STATUS] && (|device_event_flags) |=> alert_o)
    else $error("flagged device event did not raise alert");

  chk_alert_hold: assert property (
    alert_o && !alert_release_i |=> alert_o)
    else $error("alert dropped without release");

  chk_release_clear: assert property (
    ce_i && alert_release_i && !pin_src |=> !alert_o)
    else $error("release did not drop alert");

  chk_flags_hold: assert property (
    !cor_read && flag_set == 8'h00 |=> $stable(device_event_flags))
    else $error("flags changed without clear or fault");

  chk_gone_stays: assert property (
    device_event_flags == 8'h00 && (fault_i & FLAGS_USED) == 8'h00
      |=> device_event_flags == 8'h00)
    else $error("cleared flag set again without fault");
endmodule

// File: emg_host.sv
// Host model on the register strobes and the alert release line
`timescale 1ns/1ns
module emg_host (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] addr_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] wdata_o,
  output logic            release_o
);
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
    release_o = 1'b0;
  end
  // Idle address and data are inverted so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_sys_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  // Fault flags are polled, not only seen on the pin
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_sys_i);
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask
  task automatic release_alert();
    @(negedge clk_sys_i);
    release_o = 1'b1;
    @(negedge clk_sys_i);
    release_o = 1'b0;
  endtask
endmodule

// File: test_event_mask_and_global_flags.sv
// Self-checking bench for the event mask and global flag block
`timescale 1ns/1ns
module test_event_mask_and_global_flags;
  import emg_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int RF = 16;
  logic            clk_sys_i, rst_i, ce_i, alert_o, rel, wr, rd;
  logic      [7:0] addr, wdata, rdata, fault, d, e, m;
  logic [4:0][7:0] ev;
  logic      [4:0] rec;
  int              err_count, samples_checked;
  emg_top #(.REFRESH(RF)) dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .ev_pwrena_i(ev[0]), .ev_pwrgd_i(ev[1]), .ev_det_i(ev[2]),
    .ev_class_i(ev[3]), .ev_dis_i(ev[4]), .fault_i(fault), .alert_release_i(rel),
    .alert_o(alert_o), .event_record_o(rec));
  emg_host host_u (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
    .rd_o(rd), .wdata_o(wdata), .release_o(rel));
  // ------------------------------------------------------------
  // Clock, checks, verdict
  // ------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Reserved flag bits read as zero
  function automatic logic [7:0] flags_exp(input logic [7:0] f);
    return f & FLAGS_USED;
  endfunction
  task automatic print_verdict();
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Whole run is under 2000 cycles
  initial begin
    #200_000;
    err_count++;
    print_verdict();
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    err_count = 0;
    samples_checked = 0;
    void'($urandom(56));
    rst_i = 1'b1;
    ce_i = 1'b1;
    fault = 8'h00;
    ev = '0;
    repeat (3) @(negedge clk_sys_i);
    rst_i = 1'b0;
    host_u.rd(ADDR_MASK, d);
    check(d, MASK_RESET);
    // Status mask and reset flag together raise the alert
    check({7'h00, alert_o}, 8'h01);
    host_u.rd(ADDR_FLAGS, d);
    check(d, FLAGS_RESET);
    host_u.rd(ADDR_FLAGS_COR, d);
    check(d, FLAGS_RESET);
    host_u.rd(ADDR_FLAGS, d);
    check(d, 8'h00);
    host_u.rd(8'h05, d);
    check(d, 8'h00);
    fault = 8'($urandom) | 8'h08;
    repeat (2) @(negedge clk_sys_i);
    host_u.rd(ADDR_FLAGS, d);
    check(d, flags_exp(fault));
    host_u.rd(ADDR_FLAGS_COR, d);
    check(d, flags_exp(fault));
    repeat (RF + 2) @(negedge clk_sys_i);
    host_u.rd(ADDR_FLAGS, d);
    check(d, flags_exp(fault));
    e = fault;
    fault = 8'h00;
    host_u.rd(ADDR_FLAGS_COR, d);
    check(d, flags_exp(e));
    repeat (RF + 2) @(negedge clk_sys_i);
    host_u.rd(ADDR_FLAGS, d);
    check(d, 8'h00);
    // Status bit kept low so the flags cannot mask a missing event alert
    for (int t = 0; t < NUM_TYPES; t++) begin
      for (int k = 0; k < 2; k++) begin
        m = {1'b0, 7'($urandom)};
        m[t] = k[0];
        host_u.wr(ADDR_MASK, m);
        host_u.rd(ADDR_MASK, d);
        check(d, m);
        host_u.release_alert();
        check({2'b00, alert_o, rec}, 8'h00);
        e = 8'($urandom) | 8'h01;
        ev[t] = e;
        @(negedge clk_sys_i);
        ev[t] = 8'h00;
        check({2'b00, alert_o, rec}, {2'b00, k[0], 5'(1 << t)});
      end
    end
    // Last mask passes disconnect; a release in the same cycle must lose
    e = 8'($urandom) | 8'h80;
    fork
      host_u.release_alert();
      begin
        @(negedge clk_sys_i);
        ev[4] = e;
        @(negedge clk_sys_i);
        ev[4] = 8'h00;
      end
    join
    check({2'b00, alert_o, rec}, 8'h30);
    host_u.release_alert();
    // Events seen while the clock enable is low are not taken
    ce_i = 1'b0;
    ev[4] = e;
    @(negedge clk_sys_i);
    ev[4] = 8'h00;
    ce_i = 1'b1;
    check({2'b00, alert_o, rec}, 8'h00);
    print_verdict();
  end
endmodule
